// ### design/tbo_timer_outputs.sv
// Overview of operation
// RULE_01: Reset-synchronized PWM copies every buffer to its register at channel 3 match A.
// RULE_02: Buffered output compare A loads buffer at match A while the pin toggles.
// RULE_03: Buffered capture A stores count and moves old register A into buffer.
// RULE_04: Complementary PWM copies buffers at ch3 match A upward and ch4 underflow.
// RULE_05: Complementary PWM gives zero duty when ch3 register B exceeds register A.
// RULE_06: Channel 3 and 4 outputs can be disabled or inverted by control bits.
// RULE_07: Cleared master enable hands the pin to port data and direction.
// RULE_08: In PWM modes without trigger disable, ch1 capture A clears all enables.
// RULE_09: In PWM modes the level select bits invert ch3 and ch4 outputs.
// RULE_10: Compare match fires on the tick that leaves the matching count.
// RULE_11: Input capture sets the A or B flag and loads the register together.
// RULE_12: Overflow flag sets on wrap up from all ones or down from zero.
// RULE_13: Flag clears only after software reads it as one then writes zero.
// RULE_14: Each channel gives match A, match B and overflow requests, fifteen total.
// RULE_15: A request stands only while its flag and enable are both one.
// RULE_16: Channels 0 to 3 match A may trigger DMA, then CPU request is suppressed.
// RULE_17: Fixed source order after reset, channel 0 first, changeable by priority bits.
// RULE_18: Complementary PWM sets ch3 A flag only upward, ch4 overflow only on underflow.
// RULE_19: Buffer registers and transfers exist only for channels 3 and 4.
// RULE_20: Writing one, or zero without prior read as one, leaves a flag unchanged.
module tbo_timer_outputs
  import tbo_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Counter side, one entry per channel
  input tbo_pkg::tbo_chan_s [4:0] chan,
  // Mode and option bits
  input tbo_pkg::tbo_mode_e mode,
  input wire logic [1:0] bufEnA,
  input wire logic [1:0] bufEnB,
  input wire logic [1:0] captModeA,
  input wire logic [1:0] captModeB,
  input wire logic extTriggerDisable,
  input wire logic levelSelectCh3,
  input wire logic levelSelectCh4,
  input wire logic [4:0][2:0] intEnable,
  input wire logic [3:0] dmaEnable,
  input wire logic [4:0] priorityHigh,
  // Register access
  input tbo_pkg::tbo_gwr_s grAccess,
  input tbo_pkg::tbo_stat_s statAccess,
  input wire logic oeWrite,
  input wire logic [5:0] oeData,
  // Register contents
  output tbo_pkg::tbo_word_t [3:0] grValue,
  output tbo_pkg::tbo_word_t [3:0] bufValue,
  output logic [4:0][2:0] statusFlags,
  output logic [5:0] outputEnable,
  // Interrupt and DMA requests
  output logic [14:0] irqReq,
  output logic [3:0] dmaReq,
  output logic irqPending,
  output logic [3:0] irqVector,
  // Port fallback and pins
  input wire logic [5:0] portData,
  input wire logic [5:0] portDir,
  output logic [5:0] pinOut,
  output logic [5:0] pinOe
);
  import tbo_pkg::*;

  logic pwmMode;
  logic [4:0] matchA;
  logic [4:0] matchB;
  logic [4:0] capA;
  logic [4:0] capB;
  logic [4:0] overflow;
  logic [4:0][2:0] setFlag;
  logic [4:0][2:0] cpuReq;
  logic [4:0] dmaRaw;
  logic m3a;
  logic uf4;
  logic [3:0] transfer;
  logic [3:0] capture;
  logic [3:0] slotBufEn;
  logic [3:0] toggle;
  logic [3:0] next_toggle;
  logic [5:0] next_outputEnable;
  logic [5:0] wave;
  logic [5:0] next_pinOut;
  logic [5:0] next_pinOe;
  logic [2:0] pwmRaw;
  logic next_irqPending;
  logic [3:0] next_irqVector;

  assign pwmMode = (mode == TBO_RSYNC) || (mode == TBO_COMP);

  // Compare is taken on the tick that leaves the equal count
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (c >= 3)
      begin
        matchA[c] = chan[c].tick && !captModeA[c - 3]
                    && (chan[c].count == grValue[2 * (c - 3)]); // RULE_10
        matchB[c] = chan[c].tick && !captModeB[c - 3]
                    && (chan[c].count == grValue[2 * (c - 3) + 1]); // RULE_10
        capA[c] = chan[c].captA && captModeA[c - 3];
        capB[c] = chan[c].captB && captModeB[c - 3];
      end
      else
      begin
        matchA[c] = chan[c].tick && chan[c].eqA; // RULE_10
        matchB[c] = chan[c].tick && chan[c].eqB; // RULE_10
        capA[c] = chan[c].captA;
        capB[c] = chan[c].captB;
      end
      overflow[c] = chan[c].tick && (chan[c].up ? (chan[c].count == CNT_MAX)
                                                : (chan[c].count == CNT_ZERO)); // RULE_12
      setFlag[c][FLAG_A] = matchA[c] || capA[c]; // RULE_11
      setFlag[c][FLAG_B] = matchB[c] || capB[c]; // RULE_11
      setFlag[c][FLAG_OV] = overflow[c]; // RULE_12
    end
    if (mode == TBO_COMP)
    begin
      setFlag[3][FLAG_A] = matchA[3] && chan[3].up; // RULE_18
      setFlag[4][FLAG_OV] = overflow[4] && !chan[4].up; // RULE_18
    end
  end

  assign m3a = matchA[3];
  assign uf4 = overflow[4] && !chan[4].up;

  // Transfer source depends on mode; only ch3 and ch4 have buffers
  always_comb
  begin
    for (int k = 0; k < NBUF; k++)
    begin
      slotBufEn[k] = k[0] ? bufEnB[k / 2] : bufEnA[k / 2]; // RULE_19
      capture[k] = k[0] ? capB[3 + k / 2] : capA[3 + k / 2];
      if (mode == TBO_RSYNC)
        transfer[k] = m3a; // RULE_01
      else if (mode == TBO_COMP)
        transfer[k] = (m3a && chan[3].up) || uf4; // RULE_04
      else
        transfer[k] = k[0] ? matchB[3 + k / 2] : matchA[3 + k / 2]; // RULE_02
    end
  end

  genvar gk;
  generate
    for (gk = 0; gk < NBUF; gk++)
    begin : g_buf
      tbo_buf_reg u_buf
      (
        .mclk(mclk),
        .rst(rst),
        .bufEn(slotBufEn[gk]),
        .capture(capture[gk]),
        .transfer(transfer[gk]),
        .swWrGr(grAccess.wr && !grAccess.toBuf && (grAccess.sel == 2'(gk))),
        .swWrBuf(grAccess.wr && grAccess.toBuf && (grAccess.sel == 2'(gk))),
        .wdata(grAccess.data),
        .count(chan[3 + gk / 2].count),
        .gr(grValue[gk]),
        .buffer(bufValue[gk])
      );
    end
  endgenerate

  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++)
    begin : g_flag
      logic dmaSel;
      if (DMA_CH_MASK[gc])
      begin : g_dma
        assign dmaSel = dmaEnable[gc];
      end
      else
      begin : g_nodma
        assign dmaSel = 1'b0; // RULE_16
      end
      tbo_flag_unit u_flag
      (
        .mclk(mclk),
        .rst(rst),
        .set(setFlag[gc]),
        .rd(statAccess.rd && (statAccess.sel == 3'(gc))),
        .wr(statAccess.wr && (statAccess.sel == 3'(gc))),
        .wdata(statAccess.data),
        .intEnable(intEnable[gc]),
        .dmaSel(dmaSel),
        .flag(statusFlags[gc]),
        .cpuReq(cpuReq[gc]),
        .dmaReq(dmaRaw[gc])
      );
      assign irqReq[3 * gc + 2 : 3 * gc] = cpuReq[gc]; // RULE_14
    end
  endgenerate

  assign dmaReq = dmaRaw[3:0];

  // Level above ground only past the transition point, so a point beyond
  // the counting range never yields a high phase
  assign pwmRaw[0] = chan[3].count > grValue[GR_B3]; // RULE_05
  assign pwmRaw[1] = chan[4].count > grValue[GR_A4];
  assign pwmRaw[2] = chan[4].count > grValue[GR_B4];

  always_comb
  begin
    next_toggle = toggle;
    for (int k = 0; k < NBUF; k++)
    begin
      if (transfer[k] && mode == TBO_NORMAL)
        next_toggle[k] = ~toggle[k]; // RULE_02
      else if (mode == TBO_NORMAL && (k[0] ? matchB[3 + k / 2] : matchA[3 + k / 2]))
        next_toggle[k] = ~toggle[k];
    end
    if (pwmMode)
    begin
      wave[PIN_A3] = pwmRaw[0] ^ ~levelSelectCh3; // RULE_09
      wave[PIN_B3] = ~pwmRaw[0] ^ ~levelSelectCh3; // RULE_09
      wave[PIN_A4] = pwmRaw[1] ^ ~levelSelectCh4; // RULE_09
      wave[PIN_XA4] = ~pwmRaw[1] ^ ~levelSelectCh4; // RULE_09
      wave[PIN_B4] = pwmRaw[2] ^ ~levelSelectCh4; // RULE_09
      wave[PIN_XB4] = ~pwmRaw[2] ^ ~levelSelectCh4; // RULE_09
    end
    else
    begin
      wave[PIN_A3] = toggle[GR_A3];
      wave[PIN_B3] = toggle[GR_B3];
      wave[PIN_A4] = toggle[GR_A4];
      wave[PIN_B4] = toggle[GR_B4];
      wave[PIN_XA4] = 1'b0;
      wave[PIN_XB4] = 1'b0;
    end
    // Trigger wins over a software enable in the same cycle for safety
    next_outputEnable = outputEnable;
    if (pwmMode && !extTriggerDisable && chan[1].captA)
      next_outputEnable = 6'h00; // RULE_08
    else if (oeWrite)
      next_outputEnable = oeData; // RULE_06
    for (int p = 0; p < NPIN; p++)
    begin
      next_pinOut[p] = outputEnable[p] ? wave[p] : portData[p]; // RULE_06 RULE_07
      next_pinOe[p] = outputEnable[p] ? 1'b1 : portDir[p]; // RULE_07
    end
  end

  // Priority: high channels first, then low, each in channel and source order
  always_comb
  begin
    next_irqPending = 1'b0;
    next_irqVector = 4'h0;
    for (int pass = 1; pass >= 0; pass--)
    begin
      for (int s = 0; s < NSRC; s++)
      begin
        if (irqReq[s] && (priorityHigh[s / 3] == pass[0]) && !next_irqPending)
        begin
          next_irqPending = 1'b1; // RULE_17
          next_irqVector = 4'(s);
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      toggle <= 4'h0;
      outputEnable <= OE_RESET;
      pinOut <= 6'h00;
      pinOe <= 6'h00;
      irqPending <= 1'b0;
      irqVector <= 4'h0;
    end
    else
    begin
      toggle <= next_toggle;
      outputEnable <= next_outputEnable;
      pinOut <= next_pinOut;
      pinOe <= next_pinOe;
      irqPending <= next_irqPending;
      irqVector <= next_irqVector;
    end
  end

  property p_rsync_transfer;
    @(posedge mclk) disable iff (rst)
      mode == TBO_RSYNC && m3a && bufEnB[1] && !capture[GR_B4]
      |=> grValue[GR_B4] == $past(bufValue[GR_B4]);
  endproperty
  a_rsync_transfer: assert property (p_rsync_transfer) else $error("no sync transfer"); // RULE_01

  property p_comp_underflow;
    @(posedge mclk) disable iff (rst)
      mode == TBO_COMP && uf4 && bufEnB[0] && !capture[GR_B3]
      |=> grValue[GR_B3] == $past(bufValue[GR_B3]);
  endproperty
  a_comp_underflow: assert property (p_comp_underflow) else $error("no underflow transfer"); // RULE_04

  property p_ext_trigger;
    @(posedge mclk) disable iff (rst)
      pwmMode && !extTriggerDisable && chan[1].captA |=> outputEnable == 6'h00 ##1 !pinOe[0] || portDir[0];
  endproperty
  a_ext_trigger: assert property (p_ext_trigger) else $error("enables not cleared"); // RULE_08

  property p_port_fallback;
    @(posedge mclk) disable iff (rst)
      !outputEnable[PIN_B3] |=> pinOut[PIN_B3] == $past(portData[PIN_B3]);
  endproperty
  a_port_fallback: assert property (p_port_fallback) else $error("pin not released"); // RULE_07

  property p_zero_duty;
    @(posedge mclk) disable iff (rst)
      mode == TBO_COMP && outputEnable[PIN_A3] && (grValue[GR_B3] > grValue[GR_A3])
      && (chan[3].count <= grValue[GR_A3])
      |=> pinOut[PIN_A3] == ~$past(levelSelectCh3);
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("duty not zero"); // RULE_05

  property p_flag_comp_down;
    @(posedge mclk) disable iff (rst)
      mode == TBO_COMP && m3a && !chan[3].up && !statusFlags[3][FLAG_A] && !capA[3]
      |=> !statusFlags[3][FLAG_A];
  endproperty
  a_flag_comp_down: assert property (p_flag_comp_down) else $error("flag set downward"); // RULE_18
endmodule : tbo_timer_outputs

// ### include/tbo_pkg.sv
package tbo_pkg;
  localparam int NCH = 5;
  localparam int NBUF = 4;
  localparam int NPIN = 6;
  localparam int NFLAG = 3;
  localparam int NSRC = 15;

  typedef logic [15:0] tbo_word_t;
  localparam tbo_word_t CNT_MAX = 16'hffff;
  localparam tbo_word_t CNT_ZERO = 16'h0000;
  localparam tbo_word_t GR_RESET = 16'hffff;
  localparam tbo_word_t BUF_RESET = 16'hffff;

  typedef enum logic [1:0]
  {
    TBO_NORMAL = 2'b00,
    TBO_RSYNC = 2'b01,
    TBO_COMP = 2'b10
  } tbo_mode_e;

  // Flag bit positions inside one channel
  localparam int FLAG_A = 0;
  localparam int FLAG_B = 1;
  localparam int FLAG_OV = 2;

  // Buffered register slots: ch3 A, ch3 B, ch4 A, ch4 B
  localparam logic [1:0] GR_A3 = 2'h0;
  localparam logic [1:0] GR_B3 = 2'h1;
  localparam logic [1:0] GR_A4 = 2'h2;
  localparam logic [1:0] GR_B4 = 2'h3;

  // Pin positions
  localparam int PIN_A3 = 0;
  localparam int PIN_B3 = 1;
  localparam int PIN_A4 = 2;
  localparam int PIN_B4 = 3;
  localparam int PIN_XA4 = 4;
  localparam int PIN_XB4 = 5;

  localparam logic [5:0] OE_RESET = 6'h3f;
  localparam logic [4:0] DMA_CH_MASK = 5'h0f;

  typedef struct packed {
    logic tick;
    logic up;
    tbo_word_t count;
    logic eqA;
    logic eqB;
    logic captA;
    logic captB;
  } tbo_chan_s;

  typedef struct packed {
    logic wr;
    logic toBuf;
    logic [1:0] sel;
    tbo_word_t data;
  } tbo_gwr_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] sel;
    logic [2:0] data;
  } tbo_stat_s;
endpackage : tbo_pkg

// ### design/tbo_buf_reg.sv
module tbo_buf_reg
  import tbo_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic bufEn,
  input wire logic capture,
  input wire logic transfer,
  input wire logic swWrGr,
  input wire logic swWrBuf,
  input wire tbo_pkg::tbo_word_t wdata,
  input wire tbo_pkg::tbo_word_t count,
  // State
  output tbo_pkg::tbo_word_t gr,
  output tbo_pkg::tbo_word_t buffer
);
  tbo_word_t next_gr;
  tbo_word_t next_buffer;

  always_comb
  begin
    next_gr = gr;
    next_buffer = buffer;
    if (swWrGr)
      next_gr = wdata;
    if (swWrBuf)
      next_buffer = wdata;
    // Capture beats a software write in the same cycle
    if (capture)
    begin
      next_gr = count; // RULE_03
      if (bufEn)
        next_buffer = gr; // RULE_03
    end
    else if (transfer && bufEn)
      next_gr = buffer; // RULE_02
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      gr <= GR_RESET;
      buffer <= BUF_RESET;
    end
    else
    begin
      gr <= next_gr;
      buffer <= next_buffer;
    end
  end

  property p_capture_shift;
    @(posedge mclk) disable iff (rst)
      capture && bufEn |=> buffer == $past(gr) && gr == $past(count);
  endproperty
  a_capture_shift: assert property (p_capture_shift) else $error("capture shift lost"); // RULE_03

  property p_transfer;
    @(posedge mclk) disable iff (rst)
      transfer && bufEn && !capture |=> gr == $past(buffer);
  endproperty
  a_transfer: assert property (p_transfer) else $error("buffer transfer lost"); // RULE_02
endmodule : tbo_buf_reg

// ### design/tbo_flag_unit.sv
module tbo_flag_unit
  import tbo_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Events
  input wire logic [2:0] set,
  // Software access
  input wire logic rd,
  input wire logic wr,
  input wire logic [2:0] wdata,
  input wire logic [2:0] intEnable,
  input wire logic dmaSel,
  // Status and requests
  output logic [2:0] flag,
  output logic [2:0] cpuReq,
  output logic dmaReq
);
  logic [2:0] armed;
  logic [2:0] next_flag;
  logic [2:0] next_armed;
  logic [2:0] clr;

  always_comb
  begin
    next_armed = armed;
    clr = 3'h0;
    if (rd)
      next_armed = armed | flag; // RULE_13
    if (wr)
    begin
      clr = armed & ~wdata; // RULE_13 RULE_20
      next_armed = 3'h0;
    end
    // New events win over a clear in the same cycle
    next_flag = (flag & ~clr) | set;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      flag <= 3'h0;
      armed <= 3'h0;
    end
    else
    begin
      flag <= next_flag;
      armed <= next_armed;
    end
  end

  assign dmaReq = flag[FLAG_A] && intEnable[FLAG_A] && dmaSel; // RULE_16
  assign cpuReq[FLAG_A] = flag[FLAG_A] && intEnable[FLAG_A] && !dmaSel; // RULE_15 RULE_16
  assign cpuReq[FLAG_B] = flag[FLAG_B] && intEnable[FLAG_B]; // RULE_15
  assign cpuReq[FLAG_OV] = flag[FLAG_OV] && intEnable[FLAG_OV]; // RULE_15

  property p_set_wins;
    @(posedge mclk) disable iff (rst)
      set[FLAG_A] |=> flag[FLAG_A];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag set lost"); // RULE_11

  property p_no_blind_clear;
    @(posedge mclk) disable iff (rst)
      flag[FLAG_B] && !armed[FLAG_B] && !rd |=> flag[FLAG_B];
  endproperty
  a_no_blind_clear: assert property (p_no_blind_clear) else $error("flag cleared without read"); // RULE_20

  sequence s_read_set;
    flag[FLAG_OV] && rd && !wr;
  endsequence
  property p_read_then_clear;
    @(posedge mclk) disable iff (rst)
      s_read_set ##1 (wr && !wdata[FLAG_OV] && !set[FLAG_OV]) |=> !flag[FLAG_OV];
  endproperty
  a_read_then_clear: assert property (p_read_then_clear) else $error("flag not cleared"); // RULE_13
endmodule : tbo_flag_unit

// ### tb/tbo_cnt_model.sv
module tbo_cnt_model
  import tbo_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bench control
  input wire logic [4:0] run,
  input wire logic [4:0] up,
  input wire logic [4:0] load,
  input wire tbo_pkg::tbo_word_t loadVal,
  input wire logic [4:0] captA,
  input wire logic [4:0] eqA,
  // Counter side
  output tbo_pkg::tbo_chan_s [4:0] chan
);
  timeunit 1ns;
  timeprecision 1ps;
  tbo_word_t count [5];
  tbo_word_t next_count [5];

  // Tick every cycle while running, so each count is seen for one tick
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      next_count[i] = count[i];
      if (load[i])
        next_count[i] = loadVal;
      else if (run[i])
        next_count[i] = up[i] ? count[i] + 16'h0001 : count[i] - 16'h0001;
      chan[i] = '{run[i], up[i], count[i], eqA[i], 1'b0, captA[i], 1'b0};
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 5; i++)
        count[i] <= CNT_ZERO;
    end
    else
    begin
      for (int i = 0; i < 5; i++)
        count[i] <= next_count[i];
    end
  end
endmodule : tbo_cnt_model

// ### tb/tbo_timer_outputs_tb_top.sv
module tbo_timer_outputs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tbo_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] run = '0, up = '0, load = '0, captA = '0, eqA = '0;
  tbo_word_t loadVal = '0;
  tbo_chan_s [4:0] chan;
  tbo_mode_e mode = TBO_NORMAL;
  logic [1:0] bufEnA = '0, bufEnB = '0, captModeA = '0;
  logic extTriggerDisable = 1'b1, levelSelectCh3 = 1'b1, levelSelectCh4 = 1'b1;
  logic [4:0][2:0] intEnable = '0;
  logic [3:0] dmaEnable = '0;
  logic [4:0] priorityHigh = '0;
  tbo_gwr_s grAccess = '0;
  tbo_stat_s statAccess = '0;
  logic oeWrite = 1'b0;
  logic [5:0] oeData = '0, portData = 6'h15, portDir = 6'h2a;
  tbo_word_t [3:0] grValue, bufValue;
  logic [4:0][2:0] statusFlags;
  logic [5:0] outputEnable, pinOut, pinOe;
  logic [14:0] irqReq;
  logic [3:0] dmaReq, irqVector;
  logic irqPending;
  int fails = 0, n_compared = 0;

  initial
  begin
    forever #4 mclk = ~mclk;
  end

  tbo_cnt_model i_cnt (.mclk(mclk), .rst(rst), .run(run), .up(up), .load(load),
    .loadVal(loadVal), .captA(captA), .eqA(eqA), .chan(chan));

  tbo_timer_outputs i_dut (.mclk(mclk), .rst(rst), .chan(chan), .mode(mode),
    .bufEnA(bufEnA), .bufEnB(bufEnB), .captModeA(captModeA), .captModeB(2'b00),
    .extTriggerDisable(extTriggerDisable), .levelSelectCh3(levelSelectCh3),
    .levelSelectCh4(levelSelectCh4), .intEnable(intEnable), .dmaEnable(dmaEnable),
    .priorityHigh(priorityHigh), .grAccess(grAccess), .statAccess(statAccess),
    .oeWrite(oeWrite), .oeData(oeData), .grValue(grValue), .bufValue(bufValue),
    .statusFlags(statusFlags), .outputEnable(outputEnable), .irqReq(irqReq),
    .dmaReq(dmaReq), .irqPending(irqPending), .irqVector(irqVector),
    .portData(portData), .portDir(portDir), .pinOut(pinOut), .pinOe(pinOe));

  task automatic close_out();
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // Idle edge first, so back-to-back calls never drive the strobe twice in one step
  task automatic grw(logic toBuf, logic [1:0] sel, tbo_word_t d);
    cyc(1);
    grAccess = '{1'b1, toBuf, sel, d};
    cyc(1);
    grAccess.wr = 1'b0;
  endtask : grw

  task automatic stat(logic rd, logic wr, logic [2:0] ch, logic [2:0] d);
    cyc(1);
    statAccess = '{rd, wr, ch, d};
    cyc(1);
    statAccess = '0;
  endtask : stat

  // Read as one, then write zero on the very next edge, so the next scenario starts clean
  task automatic clr(logic [2:0] ch);
    cyc(1);
    statAccess = '{1'b1, 1'b0, ch, 3'h0};
    cyc(1);
    statAccess = '{1'b0, 1'b1, ch, 3'h0};
    cyc(1);
    statAccess = '0;
  endtask : clr

  task automatic ld(int ch, tbo_word_t v, logic dir);
    load[ch] = 1'b1;
    loadVal = v;
    up[ch] = dir;
    cyc(1);
    load[ch] = 1'b0;
  endtask : ld

  task automatic go(int ch, int n);
    run[ch] = 1'b1;
    cyc(n);
    run[ch] = 1'b0;
  endtask : go

  task automatic s_reset();
    chk("gr", GR_RESET, grValue[0]);
    chk("buf", BUF_RESET, bufValue[3]);
    chk("oe", OE_RESET, outputEnable);
    chk("flags", 16'h0000, statusFlags);
    chk("pinOe", OE_RESET, pinOe);
  endtask : s_reset

  task automatic s_ovf();
    intEnable[0] = 3'h4;
    ld(0, 16'hfffe, 1'b1);
    go(0, 3);
    chk("ovUp", 16'h0004, statusFlags[0]);
    chk("irqOv", 16'h0001, irqReq[2]);
    stat(1'b0, 1'b1, 3'h0, 3'h0);
    chk("noRead", 16'h0004, statusFlags[0]);
    stat(1'b1, 1'b0, 3'h0, 3'h0);
    stat(1'b0, 1'b1, 3'h0, 3'h7);
    chk("writeOne", 16'h0004, statusFlags[0]);
    clr(3'h0);
    chk("cleared", 16'h0000, statusFlags[0]);
    chk("irqGone", 16'h0000, irqReq[2]);
    ld(1, 16'h0001, 1'b0);
    go(1, 2);
    chk("ovDown", 16'h0004, statusFlags[1]);
    chk("irqMasked", 16'h0000, irqReq[5]);
    clr(3'h1);
  endtask : s_ovf

  task automatic s_cmp();
    logic p;
    bufEnA = 2'b01;
    grw(1'b0, GR_A3, 16'h0010);
    grw(1'b1, GR_A3, 16'h0020);
    ld(3, 16'h000e, 1'b1);
    p = pinOut[PIN_A3];
    run[3] = 1'b1;
    for (int i = 0; i < 20 && chan[3].count !== 16'h0010; i++) cyc(1);
    chk("earlyFlag", 16'h0000, statusFlags[3][FLAG_A]);
    cyc(1);
    run[3] = 1'b0;
    chk("matchFlag", 16'h0001, statusFlags[3][FLAG_A]);
    chk("cmpXfer", 16'h0020, grValue[GR_A3]);
    cyc(2);
    chk("toggle", {15'h0, ~p}, pinOut[PIN_A3]);
    clr(3'h3);
  endtask : s_cmp

  task automatic s_cap();
    captModeA = 2'b01;
    ld(3, 16'h1234, 1'b1);
    captA[3] = 1'b1;
    cyc(1);
    captA[3] = 1'b0;
    chk("capGr", 16'h1234, grValue[GR_A3]);
    chk("capBuf", 16'h0020, bufValue[GR_A3]);
    chk("capFlag", 16'h0001, statusFlags[3][FLAG_A]);
    captModeA = 2'b00;
    clr(3'h3);
  endtask : s_cap

  task automatic s_rsync();
    tbo_word_t e [4] = '{16'h0050, 16'h0111, 16'h0222, 16'h0333};
    mode = TBO_RSYNC;
    bufEnA = 2'b11;
    bufEnB = 2'b11;
    grw(1'b0, GR_A3, 16'h0040);
    for (int i = 0; i < 4; i++) grw(1'b1, 2'(i), e[i]);
    ld(3, 16'h003f, 1'b1);
    go(3, 3);
    for (int i = 0; i < 4; i++) chk("rsXfer", e[i], grValue[i]);
    captA[1] = 1'b1;
    cyc(1);
    captA[1] = 1'b0;
    chk("trigOff", OE_RESET, outputEnable);
    cyc(1);
    extTriggerDisable = 1'b0;
    captA[1] = 1'b1;
    cyc(1);
    captA[1] = 1'b0;
    chk("trigOn", 16'h0000, outputEnable);
    cyc(1);
    chk("portDir", portDir, pinOe);
    chk("portData", portData, pinOut);
    oeWrite = 1'b1;
    oeData = 6'h3f;
    cyc(1);
    oeWrite = 1'b0;
    extTriggerDisable = 1'b1;
    clr(3'h1);
    clr(3'h3);
  endtask : s_rsync

  task automatic s_comp();
    mode = TBO_COMP;
    bufEnA = 2'b00;
    bufEnB = 2'b01;
    grw(1'b1, GR_B3, 16'h0100);
    ld(4, 16'h0000, 1'b0);
    go(4, 2);
    chk("undXfer", 16'h0100, grValue[GR_B3]);
    chk("undFlag", 16'h0004, statusFlags[4]);
    clr(3'h4);
    grw(1'b1, GR_B3, 16'h0200);
    ld(3, 16'h0051, 1'b0);
    go(3, 2);
    chk("downKeep", 16'h0100, grValue[GR_B3]);
    chk("downFlag", 16'h0000, statusFlags[3][FLAG_A]);
    ld(3, 16'h0000, 1'b1);
    run[3] = 1'b1;
    for (int i = 0; i < 16'h52; i++)
    begin
      chk("zeroDuty", 16'h0000, pinOut[PIN_A3]);
      cyc(1);
    end
    run[3] = 1'b0;
    chk("upXfer", 16'h0200, grValue[GR_B3]);
    chk("upFlag", 16'h0001, statusFlags[3][FLAG_A]);
    levelSelectCh3 = 1'b0;
    cyc(2);
    chk("invert", 16'h0001, pinOut[PIN_A3]);
    levelSelectCh3 = 1'b1;
    clr(3'h3);
  endtask : s_comp

  task automatic s_dma();
    mode = TBO_NORMAL;
    // Match A enabled on channels 0 and 2 only
    intEnable = 15'h0041;
    dmaEnable = 4'h1;
    eqA = 5'h05;
    run = 5'h05;
    cyc(1);
    eqA = '0;
    run = '0;
    chk("dmaReq", 16'h0001, dmaReq[0]);
    chk("cpuSupp", 16'h0000, irqReq[0]);
    chk("irqA2", 16'h0001, irqReq[6]);
    cyc(1);
    chk("pend", 16'h0001, irqPending);
    chk("vecDma", 16'h0006, irqVector);
    dmaEnable = 4'h0;
    cyc(2);
    chk("vecFixed", 16'h0000, irqVector);
    priorityHigh = 5'h04;
    cyc(2);
    chk("vecPrio", 16'h0006, irqVector);
  endtask : s_dma

  // Whole run is about two hundred cycles; 5000, over twenty times that, means a hang
  initial
  begin
    repeat (5000) @(posedge mclk);
    fails++;
    close_out();
  end

  initial
  begin
    cyc(20);
    rst = 1'b0;
    cyc(1);
    s_reset();
    s_ovf();
    s_cmp();
    s_cap();
    s_rsync();
    s_comp();
    s_dma();
    close_out();
  end
endmodule : tbo_timer_outputs_tb_top
